//--- verilog/nvmc_ctrl.sv
// nvmc_ctrl: self-programming control of flash and data eeprom
// assumes: core drives the register port on ref_clk, array answers
// ee_rdata combinationally from ee_addr and pulses mem_done on ref_clk
//
// Operation
// R1 - control bit 7 set targets flash program memory, clear targets eeprom.
// R2 - control bit 6 set targets the configuration registers instead.
// R3 - control bit 5 is unimplemented and always reads zero.
// R4 - bit 4 makes the next start erase the row at the table pointer, auto-cleared.
// R5 - bit 3 flags a write cut short by reset or an improper start, cleared on success.
// R6 - bit 2 must be set for any write or erase cycle to be allowed.
// R7 - setting bit 1 starts a self-timed cycle that hardware clears at the end.
// R8 - software can only set the start bit; writing zero has no effect.
// R9 - software writes 0x55 then 0xAA to the unlock register before the start.
// R10 - the core is stalled during a flash row erase until it finishes.
// R11 - each table store puts one byte in the holding register only.
// R12 - software should mask interrupts across the unlock and start writes; the bench launch task leaves the interrupt mask as it is.
// R13 - an eeprom read puts the addressed byte in the data register after one cycle.
// R14 - completion clears the start bit and sets the done flag, cleared by software.
// R15 - start is ignored unless write enable was set by an earlier write.
// R16 - control, address and data registers ignore writes during a cycle.
// R17 - start is ignored unless the two unlock writes came right before it.
`timescale 1ns/1ps
`default_nettype none
module nvmc_ctrl #(
  parameter int EE_AW      = 10,
  parameter int HOLD_DEPTH = 64
) (
  input  wire  logic               ref_clk,
  input  wire  logic               rst,
  input  wire  nvmc_pkg::nvmc_bus_t bus,
  output logic [7:0]               rdata,
  input  wire  logic               abort_reset,
  input  wire  logic               mem_done,
  input  wire  logic [7:0]         ee_rdata,
  output logic [EE_AW-1:0]         ee_addr,
  output nvmc_pkg::nvmc_cmd_t      mem_cmd,
  output logic                     core_stall,
  output logic                     irq
);
  import nvmc_pkg::*;
  localparam int HW = $clog2(HOLD_DEPTH);
  localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_DEPTH - 1);
  function automatic logic sel(input logic [3:0] a, input logic [3:0] o);
    return a == o;
  endfunction
  // ----------------------------------------
  // state
  // ----------------------------------------
  nvmc_state_t       state;
  nvmc_unlock_t      ulk;
  logic              c_flash;
  logic              c_cfg;
  logic              c_erase;
  logic              c_fault;
  logic              c_en;
  logic              c_start;
  logic              read_pend;
  logic [7:0]        data_reg;
  logic [CMD_AW-1:0] tp;
  logic [7:0]        hold [HOLD_DEPTH];
  logic [HW-1:0]     idx;
  logic [IRQ_W-1:0]  stat;
  logic [IRQ_W-1:0]  mask;
  logic              op_erase;
  logic              op_xfer;
  logic busy;
  logic wr_ctrl;
  logic start_req;
  logic go;
  logic improper;
  logic abort_hit;
  logic done_ok;
  logic [IRQ_W-1:0] next_stat;
  assign busy      = state != ST_IDLE;
  assign wr_ctrl   = bus.wr && sel(bus.addr, OFS_CTRL);
  assign start_req = wr_ctrl && bus.wdata[B_START] && !busy;
  // R6 enable gate
  // R15 enable from before
  // R17 unlock just before
  assign go        = start_req && ulk == UL_TWO && c_en && !abort_reset;
  assign improper  = start_req && !go;
  assign abort_hit = abort_reset && busy;
  assign done_ok   = state == ST_WAIT && mem_done && !abort_reset;
  // ----------------------------------------
  // unlock sequence
  // ----------------------------------------
  // R9 key sequence
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ulk <= UL_NONE;
    end else if (bus.wr) begin
      if (sel(bus.addr, OFS_UNLOCK) && bus.wdata == KEY_FIRST) begin
        ulk <= UL_ONE;
      end else if (sel(bus.addr, OFS_UNLOCK) && bus.wdata == KEY_SECOND
                   && ulk == UL_ONE) begin
        ulk <= UL_TWO;
      end else begin
        ulk <= UL_NONE;
      end
    end
  end
  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      c_flash <= 1'b0;
      c_cfg   <= 1'b0;
      c_erase <= 1'b0;
      c_en    <= 1'b0;
    end else if (wr_ctrl && !busy) begin
      // R16 locked while busy
      c_flash <= bus.wdata[B_FLASH];
      c_cfg   <= bus.wdata[B_CFG];
      c_erase <= bus.wdata[B_ERASE];
      c_en    <= bus.wdata[B_EN];
    end else if (done_ok && op_erase) begin
      // R4 erase auto clear
      c_erase <= 1'b0;
    end
  end
  // R5 fault flag
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      c_fault <= 1'b0;
    end else if (abort_hit || improper) begin
      c_fault <= 1'b1;
    end else if (done_ok) begin
      c_fault <= 1'b0;
    end else if (wr_ctrl && !busy && !bus.wdata[B_FAULT]) begin
      c_fault <= 1'b0;
    end
  end
  // R7 start set and clear
  // R8 only hardware clears
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      c_start <= 1'b0;
    end else if (go) begin
      c_start <= 1'b1;
    end else if (done_ok || abort_hit) begin
      c_start <= 1'b0;
    end
  end
  // ----------------------------------------
  // address, data, table pointer, holding
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ee_addr <= '0;
      tp      <= '0;
    end else if (bus.wr && !busy) begin
      if (sel(bus.addr, OFS_ADR_LO)) begin
        ee_addr[7:0] <= bus.wdata;
      end else if (sel(bus.addr, OFS_ADR_HI)) begin
        ee_addr[EE_AW-1:8] <= bus.wdata[EE_AW-9:0];
      end else if (sel(bus.addr, OFS_TP_LO)) begin
        tp[7:0] <= bus.wdata;
      end else if (sel(bus.addr, OFS_TP_HI)) begin
        tp[15:8] <= bus.wdata;
      end
    end
  end
  // R13 eeprom read
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      read_pend <= 1'b0;
      data_reg  <= BYTE_RST;
    end else begin
      read_pend <= wr_ctrl && !busy && bus.wdata[B_READ]
                   && !bus.wdata[B_FLASH] && !bus.wdata[B_CFG];
      if (read_pend) begin
        data_reg <= ee_rdata;
      end else if (bus.wr && sel(bus.addr, OFS_DATA) && !busy) begin
        data_reg <= bus.wdata;
      end
    end
  end
  // R11 one byte per store
  always_ff @(posedge ref_clk) begin
    if (bus.wr && sel(bus.addr, OFS_TSTORE) && !busy) begin
      hold[tp[HW-1:0]] <= bus.wdata;
    end
  end
  // ----------------------------------------
  // cycle sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state    <= ST_IDLE;
      idx      <= '0;
      op_erase <= 1'b0;
      op_xfer  <= 1'b0;
    end else if (abort_hit) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (go) begin
            op_erase <= bus.wdata[B_ERASE] && bus.wdata[B_FLASH]
                        && !bus.wdata[B_CFG];
            op_xfer  <= !bus.wdata[B_ERASE] && bus.wdata[B_FLASH]
                        && !bus.wdata[B_CFG];
            idx      <= '0;
            state    <= (!bus.wdata[B_ERASE] && bus.wdata[B_FLASH]
                         && !bus.wdata[B_CFG]) ? ST_XFER : ST_KICK;
          end
        end
        ST_XFER: begin
          idx <= idx + 1'b1;
          if (idx == HOLD_LAST) begin
            state <= ST_KICK;
          end
        end
        ST_KICK: begin
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (mem_done) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  // R1 space select
  // R2 config select
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_cmd <= '0;
    end else begin
      mem_cmd.valid <= 1'b0;
      mem_cmd.start <= 1'b0;
      mem_cmd.erase <= op_erase;
      mem_cmd.flash <= c_flash;
      mem_cmd.cfg   <= c_cfg;
      if (state == ST_XFER && !abort_reset) begin
        mem_cmd.valid <= 1'b1;
        mem_cmd.addr  <= {tp[CMD_AW-1:HW], idx};
        mem_cmd.data  <= hold[idx];
      end else if (state == ST_KICK && !abort_reset) begin
        mem_cmd.start <= 1'b1;
        mem_cmd.addr  <= c_flash ? tp : CMD_AW'(ee_addr);
        mem_cmd.data  <= data_reg;
      end
    end
  end
  // R10 stall on row erase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      core_stall <= 1'b0;
    end else if (go && bus.wdata[B_ERASE] && bus.wdata[B_FLASH]
                 && !bus.wdata[B_CFG]) begin
      core_stall <= 1'b1;
    end else if (done_ok || abort_hit) begin
      core_stall <= 1'b0;
    end
  end
  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  // R14 done flag
  always_comb begin
    next_stat = stat;
    if (bus.wr && sel(bus.addr, OFS_STAT)) begin
      next_stat = stat & ~bus.wdata[IRQ_W-1:0];
    end
    if (done_ok) begin
      next_stat[I_DONE] = 1'b1;
    end
    if (abort_hit || improper) begin
      next_stat[I_FAULT] = 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat <= '0;
      mask <= '0;
      irq  <= 1'b0;
    end else begin
      stat <= next_stat;
      irq  <= |(stat & mask);
      if (bus.wr && sel(bus.addr, OFS_MASK)) begin
        mask <= bus.wdata[IRQ_W-1:0];
      end
    end
  end
  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= BYTE_RST;
    end else if (bus.rd) begin
      if (sel(bus.addr, OFS_CTRL)) begin
        // R3 bit five zero
        rdata <= {c_flash, c_cfg, 1'b0, c_erase, c_fault, c_en, c_start,
                  read_pend};
      end else if (sel(bus.addr, OFS_ADR_LO)) begin
        rdata <= ee_addr[7:0];
      end else if (sel(bus.addr, OFS_ADR_HI)) begin
        rdata <= 8'(ee_addr >> 8);
      end else if (sel(bus.addr, OFS_DATA)) begin
        rdata <= data_reg;
      end else if (sel(bus.addr, OFS_TP_LO)) begin
        rdata <= tp[7:0];
      end else if (sel(bus.addr, OFS_TP_HI)) begin
        rdata <= tp[15:8];
      end else if (sel(bus.addr, OFS_STAT)) begin
        rdata <= 8'(stat);
      end else if (sel(bus.addr, OFS_MASK)) begin
        rdata <= 8'(mask);
      end else begin
        rdata <= BYTE_RST;
      end
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_enable_before_start: assert property ( // R15
    start_req && !c_en |=> !c_start && state == ST_IDLE)
    else $error("start accepted without earlier enable");
  a_unlock_before_start: assert property ( // R17
    start_req && ulk != UL_TWO |=> !c_start)
    else $error("start accepted without unlock");
  a_start_sticky: assert property ( // R8
    c_start && !mem_done && !abort_reset |=> c_start)
    else $error("start bit dropped early");
  a_done_clears_start: assert property ( // R14
    done_ok |=> !c_start && stat[I_DONE] && state == ST_IDLE)
    else $error("completion not reported");
  a_stall_during_erase: assert property ( // R10
    go && bus.wdata[B_ERASE] && bus.wdata[B_FLASH] && !bus.wdata[B_CFG]
    |=> core_stall throughout (c_start [*2]))
    else $error("core not stalled in erase");
  a_ctrl_bit5_zero: assert property ( // R3
    bus.rd && sel(bus.addr, OFS_CTRL) |=> !rdata[5])
    else $error("bit 5 reads one");
  a_abort_faults: assert property ( // R5
    abort_hit |=> c_fault && !c_start && !core_stall)
    else $error("abort not flagged");
  a_read_one_cycle: assert property ( // R13
    wr_ctrl && !busy && bus.wdata[B_READ] && !bus.wdata[B_FLASH]
    && !bus.wdata[B_CFG] |=> ##1 data_reg == $past(ee_rdata))
    else $error("eeprom byte not captured");
  a_data_locked_busy: assert property ( // R16
    busy && !read_pend |=> $stable(data_reg) && $stable(ee_addr))
    else $error("registers changed while busy");
  a_erase_autoclear: assert property ( // R4
    done_ok && op_erase |=> !c_erase)
    else $error("erase enable not cleared");
  a_kick_space: assert property ( // R1
    mem_cmd.start |-> mem_cmd.flash == c_flash && mem_cmd.cfg == c_cfg)
    else $error("wrong target space");
  c_flash_write: cover property (state == ST_XFER ##[1:300] done_ok);
  c_row_erase: cover property (core_stall ##[1:300] done_ok);
  c_bad_start: cover property (improper);
  c_aborted: cover property (abort_hit);

endmodule // nvmc_ctrl
`default_nettype wire

//--- shared/nvmc_pkg.sv
// nvmc_pkg: shared constants and types of the nvm program/erase control
// assumes: 8-bit register port, memory array on the same clock
package nvmc_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_UNLOCK = 4'h1;
  localparam logic [3:0] OFS_ADR_LO = 4'h2;
  localparam logic [3:0] OFS_ADR_HI = 4'h3;
  localparam logic [3:0] OFS_DATA   = 4'h4;
  localparam logic [3:0] OFS_TP_LO  = 4'h5;
  localparam logic [3:0] OFS_TP_HI  = 4'h6;
  localparam logic [3:0] OFS_TSTORE = 4'h7;
  localparam logic [3:0] OFS_STAT   = 4'h8;
  localparam logic [3:0] OFS_MASK   = 4'h9;
  // ----------------------------------------
  // control bit positions
  // ----------------------------------------
  localparam int B_FLASH = 7;
  localparam int B_CFG   = 6;
  localparam int B_ERASE = 4;
  localparam int B_FAULT = 3;
  localparam int B_EN    = 2;
  localparam int B_START = 1;
  localparam int B_READ  = 0;
  // ----------------------------------------
  // interrupt bits, keys, reset values
  // ----------------------------------------
  localparam int I_DONE  = 0;
  localparam int I_FAULT = 1;
  localparam int IRQ_W   = 2;
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] BYTE_RST   = 8'h00;
  localparam int CMD_AW = 16;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [3:0]       addr;
    logic [7:0]       wdata;
  } nvmc_bus_t;
  typedef struct packed {
    logic              valid;
    logic              start;
    logic              erase;
    logic              flash;
    logic              cfg;
    logic [CMD_AW-1:0] addr;
    logic [7:0]        data;
  } nvmc_cmd_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_XFER = 4'b0010,
    ST_KICK = 4'b0100,
    ST_WAIT = 4'b1000
  } nvmc_state_t;
  typedef enum logic [1:0] {
    UL_NONE = 2'b00,
    UL_ONE  = 2'b01,
    UL_TWO  = 2'b10
  } nvmc_unlock_t;
endpackage

//--- bench/nvmc_array_model.sv
// nvmc_array_model: behavioural flash and eeprom array beside the control
// assumes: one clock, command fields as nvmc_ctrl drives them
`timescale 1ns/1ps
`default_nettype none
module nvmc_array_model
  import nvmc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire nvmc_cmd_t  cmd,
  input  wire logic [9:0] ee_addr,
  input  wire logic [7:0] dly,
  output logic            mem_done,
  output logic [7:0]      ee_rdata
);
  logic [8:0] cnt;
  assign ee_rdata = ee_addr[7:0] ^ 8'hA5;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt <= 9'h000;
    end else if (cmd.start) begin
      cnt <= {1'b0, dly};
    end else if (cnt != 9'h000) begin
      cnt <= cnt - 9'h001;
    end
  end
  assign mem_done = (cnt == 9'h001);
endmodule // nvmc_array_model
`default_nettype wire

//--- bench/nvmc_ctrl_tb.sv
// nvmc_ctrl_tb: self-checking bench with a register-level model
// assumes: nvmc_ctrl, nvmc_array_model, nvmc_pkg compiled before
`timescale 1ns/1ps
`default_nettype none
module nvmc_ctrl_tb;
  import nvmc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        abort_reset = 1'b0;
  logic [7:0]  dly = 8'h10;
  nvmc_bus_t   bus = '0;
  logic [7:0]  rdata;
  logic        mem_done;
  logic [7:0]  ee_rdata;
  logic [9:0]  ee_addr;
  nvmc_cmd_t   cmd;
  nvmc_cmd_t   last;
  logic        core_stall;
  logic        irq;
  logic        stall_at;
  logic [7:0]  got [4];
  logic [7:0]  hexp [4];
  logic [15:0] vaddr;
  int          bad_count = 0;
  int          checks = 0;
  int          scnt = 0;
  int          vcnt = 0;
  int          ul = 0;
  int unsigned seed = 90679;
  logic [7:0]  m_ctrl = 8'h00;
  logic [7:0]  m_stat = 8'h00;
  logic [7:0]  m_data = 8'h00;
  logic [7:0]  x;

  always #25 ref_clk = ~ref_clk;

  nvmc_ctrl u_dut (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata),
    .abort_reset(abort_reset), .mem_done(mem_done), .ee_rdata(ee_rdata),
    .ee_addr(ee_addr), .mem_cmd(cmd), .core_stall(core_stall), .irq(irq));
  nvmc_array_model u_arr (.ref_clk(ref_clk), .rst(rst), .cmd(cmd),
    .ee_addr(ee_addr), .dly(dly), .mem_done(mem_done), .ee_rdata(ee_rdata));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic final_report();
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // model update and one write cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic go;
    logic busy;
    @(posedge ref_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    busy = m_ctrl[1];
    go = d[1] && m_ctrl[2] && ul == 2 && !busy;
    if (a == OFS_CTRL && !busy) begin
      m_ctrl = {d[7:6], 1'b0, d[4], (d[3] & m_ctrl[3]) | (d[1] & !go),
                d[2], go, 1'b0};
      if (d[1] && !go) m_stat[1] = 1'b1;
    end
    if (a == OFS_DATA && !busy) m_data = d;
    if (a == OFS_STAT) m_stat = m_stat & ~d;
    if (a == OFS_UNLOCK && d == KEY_FIRST) ul = 1;
    else if (a == OFS_UNLOCK && d == KEY_SECOND && ul == 1) ul = 2;
    else ul = 0;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge ref_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1;
    chk(n, {8'h00, e}, {8'h00, rdata});
  endtask

  // unlock then start, interrupt mask left as it is meanwhile
  task automatic launch(input logic [7:0] c);
    wr(OFS_UNLOCK, KEY_FIRST);
    wr(OFS_UNLOCK, KEY_SECOND);
    wr(OFS_CTRL, c);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (m_ctrl[1] && n < 500) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 500) chk("done wait", 16'h0001, 16'h0000);
    repeat (2) @(posedge ref_clk);
  endtask

  // ----------------------------------------
  // monitor and completion model
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (cmd.valid) begin
      if (vcnt < 4) got[vcnt] = cmd.data;
      if (vcnt == 0) vaddr = cmd.addr;
      vcnt++;
    end
    if (cmd.start) begin
      scnt++;
      last = cmd;
      stall_at = core_stall;
    end
    if (mem_done && m_ctrl[1]) begin
      m_ctrl[1] = 1'b0;
      m_ctrl[3] = 1'b0;
      m_ctrl[4] = 1'b0;
      m_stat[0] = 1'b1;
    end
  end

  initial begin
    #(50 * 20000);
    bad_count++;
    final_report();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFS_CTRL, 8'h00, "ctrl reset");
    rd(4'hF, 8'h00, "unmapped");
    wr(4'hF, 8'hFF);
    wr(OFS_CTRL, 8'h24);
    rd(OFS_CTRL, m_ctrl, "bit5");
    wr(OFS_CTRL, 8'h00);
    launch(8'h06);
    rd(OFS_CTRL, m_ctrl, "same write en");
    wr(OFS_CTRL, 8'h04);
    wr(OFS_UNLOCK, KEY_FIRST);
    wr(OFS_ADR_LO, 8'h00);
    wr(OFS_UNLOCK, KEY_SECOND);
    wr(OFS_CTRL, 8'h06);
    rd(OFS_CTRL, m_ctrl, "broken unlock");
    wr(OFS_CTRL, 8'h00);
    launch(8'h02);
    rd(OFS_STAT, m_stat, "fault stat");
    chk("no start", 16'h0000, 16'(scnt));
    x = rnd();
    wr(OFS_ADR_LO, x);
    wr(OFS_ADR_HI, 8'h01);
    wr(OFS_DATA, ~x);
    wr(OFS_CTRL, 8'h04);
    wr(OFS_STAT, 8'h03);
    wr(OFS_MASK, 8'h01);
    dly <= 8'd12 + 8'(rnd() % 32);
    launch(8'h06);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_DATA, 8'h00);
    rd(OFS_CTRL, m_ctrl, "busy ctrl");
    wait_done();
    chk("ee start", 16'h0001, 16'(scnt));
    chk("ee addr", {6'h00, 2'b01, x}, last.addr);
    chk("ee flash", 16'h0000, {15'h0000, last.flash});
    chk("ee data", {8'h00, m_data}, {8'h00, last.data});
    rd(OFS_CTRL, m_ctrl, "done ctrl");
    rd(OFS_STAT, m_stat, "done stat");
    chk("irq on", 16'h0001, {15'h0000, irq});
    wr(OFS_STAT, 8'h01);
    repeat (3) @(posedge ref_clk);
    chk("irq off", 16'h0000, {15'h0000, irq});
    wr(OFS_CTRL, 8'h01);
    repeat (3) @(posedge ref_clk);
    rd(OFS_DATA, x ^ 8'hA5, "ee read");
    wr(OFS_TP_HI, 8'h12);
    for (int i = 0; i < 4; i++) begin
      hexp[i] = rnd();
      wr(OFS_TP_LO, 8'(i));
      wr(OFS_TSTORE, hexp[i]);
    end
    chk("no early xfer", 16'h0000, 16'(vcnt));
    wr(OFS_CTRL, 8'h84);
    launch(8'h86);
    wait_done();
    chk("xfer count", 16'd64, 16'(vcnt));
    chk("xfer addr", 16'h1200, vaddr);
    for (int i = 0; i < 4; i++) chk("hold", hexp[i], got[i]);
    wr(OFS_CTRL, 8'h94);
    launch(8'h96);
    wait_done();
    chk("erase", 16'h0001, {15'h0000, last.erase});
    chk("stall", 16'h0001, {15'h0000, stall_at});
    chk("stall off", 16'h0000, {15'h0000, core_stall});
    rd(OFS_CTRL, m_ctrl, "erase clr");
    wr(OFS_CTRL, 8'h44);
    launch(8'h46);
    wait_done();
    chk("cfg", 16'h0001, {15'h0000, last.cfg});
    wr(OFS_CTRL, 8'h04);
    dly <= 8'd60;
    launch(8'h06);
    repeat (4) @(posedge ref_clk);
    abort_reset <= 1'b1;
    @(posedge ref_clk);
    abort_reset <= 1'b0;
    m_ctrl[1] = 1'b0;
    m_ctrl[3] = 1'b1;
    m_stat[1] = 1'b1;
    repeat (70) @(posedge ref_clk);
    rd(OFS_CTRL, m_ctrl, "abort ctrl");
    rd(OFS_STAT, m_stat, "abort stat");
    final_report();
  end
endmodule // nvmc_ctrl_tb
`default_nettype wire
